// [bench/ddrtm_ctrl_model.sv]
/*
 Controller-side link model: free-running link clock and one command per call, after a catch-up refresh when one is due.
 Assumes mclk is the bench clock; pins change just after its rising edge.
*/
`timescale 1ns/1ns
`include "ddrtm_map.vh"
module ddrtm_ctrl_model (
    // Bench clock
    input wire mclk,
    // Temperature range, high for extended
    input wire temp_ext,
    // Link pins
    output reg link_ck,
    output reg cke,
    output reg [3:0] cmd_b
);
    realtime last_ref;
    // ==========
    // Link clock, 400 ns, phase unrelated to mclk
    initial
    begin
        link_ck = 1'b0;
        cke = 1'b1;
        cmd_b = 4'hf;
        last_ref = 0.0;
        #37;
        forever #200 link_ck = ~link_ck;
    end
    // ==========
    // Pins change mid-period and hold for a full link cycle
    function integer refi_ns(input ext);
    begin
        refi_ns = ext ? `DDRTM_REFI_EXTENDED_NS : `DDRTM_REFI_NORMAL_NS;
    end
    endfunction
    task drive(input [3:0] code);
    begin
        @(negedge link_ck);
        @(posedge mclk);
        cmd_b <= code;
        if (code == `DDRTM_CMD_REF)
            last_ref = $realtime;
        @(negedge link_ck);
        @(posedge mclk);
        cmd_b <= 4'hf;
    end
    endtask
    // Catch-up refresh once the interval of the current range has run out
    task issue(input [3:0] code);
    begin
        if (code != `DDRTM_CMD_REF && $realtime - last_ref > refi_ns(temp_ext))
            drive(`DDRTM_CMD_REF);
        drive(code);
    end
    endtask
    // No write with auto-precharge is sent, so no recovery wait is owed
    task set_cke(input v);
    begin
        @(negedge link_ck);
        @(posedge mclk);
        cke <= v;
        if (v)
            repeat (10) @(posedge link_ck);
    end
    endtask
endmodule

// [bench/ddrtm_top_monitor.sv]
/*
 Checker of ddrtm_top status outputs.
 Assumes a link clock of eight MCLK_I periods.
*/
`timescale 1ns/1ns
module ddrtm_top_monitor (
    // Clock and reset
    input wire MCLK_I,
    input wire RST_B_I,
    // Status
    input wire WRITE_START_O,
    input wire REFRESH_BUSY_O,
    input wire ROW_BUSY_O,
    input wire ZQ_BUSY_O,
    input wire POWERDOWN_O,
    input wire LEVEL_STROBE_OK_O,
    input wire LEVEL_EDGE_OK_O
);
    reg [9:0] zq_len;
    reg [9:0] row_len;
    reg [9:0] lev_len;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);
    // ==========
    // Cycles spent in the calibration busy, row busy and strobe flag levels
    always @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            zq_len <= 10'h0;
            row_len <= 10'h0;
            lev_len <= 10'h0;
        end
        else
        begin
            zq_len <= ZQ_BUSY_O ? zq_len + 10'h1 : 10'h0;
            row_len <= ROW_BUSY_O ? row_len + 10'h1 : 10'h0;
            lev_len <= LEVEL_STROBE_OK_O ? lev_len + 10'h1 : 10'h0;
        end
    end
    sequence s_ref_hold;
        REFRESH_BUSY_O [*6] ##1 !REFRESH_BUSY_O;
    endsequence
    a_refresh_span: assert property ($rose(REFRESH_BUSY_O) |-> s_ref_hold)
        else $error("refresh busy span wrong");
    a_pd_after_ops: assert property ($rose(POWERDOWN_O) |-> !REFRESH_BUSY_O && !ROW_BUSY_O)
        else $error("power-down before operations ended");
    a_write_pulse: assert property (WRITE_START_O |=> !WRITE_START_O)
        else $error("write start longer than one cycle");
    a_zq_span: assert property ($fell(ZQ_BUSY_O) |-> zq_len >= 10'h1f9 && zq_len <= 10'h207)
        else $error("calibration busy span wrong");
    a_row_span: assert property ($fell(ROW_BUSY_O) |-> row_len >= 10'h01e && row_len <= 10'h022)
        else $error("row busy span wrong");
    a_level_order: assert property (LEVEL_EDGE_OK_O |-> LEVEL_STROBE_OK_O)
        else $error("edge flag without strobe flag");
    a_level_gap: assert property ($rose(LEVEL_EDGE_OK_O) |-> lev_len >= 10'h076 && lev_len <= 10'h07a)
        else $error("leveling flags spacing wrong");
endmodule
bind ddrtm_top ddrtm_top_monitor mon (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .WRITE_START_O(WRITE_START_O),
    .REFRESH_BUSY_O(REFRESH_BUSY_O), .ROW_BUSY_O(ROW_BUSY_O), .ZQ_BUSY_O(ZQ_BUSY_O), .POWERDOWN_O(POWERDOWN_O),
    .LEVEL_STROBE_OK_O(LEVEL_STROBE_OK_O), .LEVEL_EDGE_OK_O(LEVEL_EDGE_OK_O));

// [bench/ddrtm_top_tb.sv]
/*
 Self-checking bench of ddrtm_top.
 Assumes the controller model drives every link pin except CHOP_OTF_I, which the bench drives.
*/
`timescale 1ns/1ns
`include "ddrtm_map.vh"
module ddrtm_top_tb;
    reg mclk = 1'b0;
    reg rst_b = 1'b0;
    reg [5:0] wl = 6'h05;
    reg chop_fixed = 1'b0;
    reg chop_otf = 1'b0;
    reg level_mode = 1'b0;
    reg temp_ext = 1'b0;
    wire link_ck, cke, wstart, rbusy, row_busy, zq_busy, pd, strobe_ok, edge_ok;
    wire [3:0] cmd_b;
    integer num_errors = 0;
    integer comparisons = 0;
    integer hits = 0;
    integer i, n, seed;
    ddrtm_ctrl_model ctrl (.mclk(mclk), .temp_ext(temp_ext), .link_ck(link_ck), .cke(cke), .cmd_b(cmd_b));
    ddrtm_top uut (.MCLK_I(mclk), .RST_B_I(rst_b), .LINK_CK_I(link_ck), .CKE_I(cke), .CS_B_I(cmd_b[3]),
        .RAS_B_I(cmd_b[2]), .CAS_B_I(cmd_b[1]), .WE_B_I(cmd_b[0]), .CHOP_OTF_I(chop_otf), .WRITE_LATENCY_I(wl),
        .CHOP_FIXED_I(chop_fixed), .LEVEL_MODE_I(level_mode), .WRITE_START_O(wstart), .REFRESH_BUSY_O(rbusy),
        .ROW_BUSY_O(row_busy), .ZQ_BUSY_O(zq_busy), .POWERDOWN_O(pd), .LEVEL_STROBE_OK_O(strobe_ok),
        .LEVEL_EDGE_OK_O(edge_ok));
    initial forever #25 mclk = ~mclk;
    always @(posedge mclk) hits <= hits + (wstart === 1'b1);
    task chk(input [95:0] name, input [31:0] exp, input [31:0] got);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %0s expected %0d seen %0d", name, exp, got);
        end
    end
    endtask
    // Settles eight mclk cycles (a full link period) after the k-th next link edge, just before the next one is detected
    task links(input integer k);
    begin
        repeat (k) @(posedge link_ck);
        repeat (8) @(posedge mclk);
    end
    endtask
    task stop_test;
    begin
        if (num_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        #1000000;
        num_errors = num_errors + 1;
        stop_test;
    end
    initial
    begin
        seed = $urandom(32'h23dc);
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        temp_ext <= $urandom % 2;
        repeat (8) @(posedge mclk);
        for (i = 0; i < 4; i = i + 1)
        begin
            wl <= 6'h01 + $urandom % 12;
            chop_fixed <= i[0];
            chop_otf <= $urandom % 2;
            ctrl.issue(`DDRTM_CMD_WR);
            n = hits;
            links((i[0] ? `DDRTM_WSTART_BC4_CK : `DDRTM_WSTART_BL8_CK) + wl - 1);
            chk("early_write", 0, hits - n);
            links(1);
            chk("write_start", 1, hits - n);
        end
        ctrl.issue(`DDRTM_CMD_REF);
        repeat (2) @(posedge mclk);
        chk("ref_busy", 1, rbusy);
        repeat (6) @(posedge mclk);
        chk("ref_done", 0, rbusy);
        ctrl.issue(`DDRTM_CMD_ACT);
        ctrl.set_cke(1'b0);
        links(1);
        chk("row_busy", 1, row_busy);
        chk("pd_held", 0, pd);
        links(2);
        chk("pd_entered", 1, pd);
        ctrl.set_cke(1'b1);
        links(1);
        chk("pd_exit", 0, pd);
        ctrl.issue(`DDRTM_CMD_PRE);
        links(1);
        chk("pre_busy", 1, row_busy);
        ctrl.issue(`DDRTM_CMD_ZQ);
        links(63);
        chk("zq_busy", 1, zq_busy);
        links(1);
        chk("zq_done", 0, zq_busy);
        level_mode <= 1'b1;
        links(23);
        chk("strobe_early", 0, strobe_ok);
        links(3);
        chk("strobe_ok", 1, strobe_ok);
        links(12);
        chk("edge_early", 0, edge_ok);
        links(3);
        chk("edge_ok", 1, edge_ok);
        level_mode <= 1'b0;
        links(1);
        chk("level_clear", 0, strobe_ok);
        stop_test;
    end
endmodule

// [hw/ddrtm_map.vh]
/*
 Timing constants for the refresh, leveling and write-start tracker.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef DDRTM_MAP_VH
`define DDRTM_MAP_VH
// ==========================================
// Write leveling waits, in link clock cycles
`define DDRTM_LEVEL_FIRST_STROBE_CK 8'd40
`define DDRTM_LEVEL_STROBE_DRIVE_CK 8'd25
// ==========================================
// Refresh timing
`define DDRTM_REFRESH_CYCLE_NS 260
`define DDRTM_REFI_NORMAL_NS 7800
`define DDRTM_REFI_EXTENDED_NS 3900
// ==========================================
// Internal write start offsets after write latency
`define DDRTM_WSTART_BL8_CK 6'd4
`define DDRTM_WSTART_BC4_CK 6'd2
// ==========================================
// Short calibration span
`define DDRTM_ZQCS_CK 8'd64
// ==========================================
// Command encodings {cs_b, ras_b, cas_b, we_b}
`define DDRTM_CMD_MRS 4'h0
`define DDRTM_CMD_REF 4'h1
`define DDRTM_CMD_PRE 4'h2
`define DDRTM_CMD_ACT 4'h3
`define DDRTM_CMD_WR 4'h4
`define DDRTM_CMD_RD 4'h5
`define DDRTM_CMD_ZQ 4'h6
`endif

// [hw/ddrtm_sync.v]
/*
 Two flip-flop synchroniser for a bus of asynchronous levels.
 Assumes the destination clock is MCLK_I domain; reset is active low async.
*/
`timescale 1ns/1ns
module ddrtm_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // Data
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1 <= d_i;
            stage2 <= stage1;
        end
    end
    assign q_o = stage2;
endmodule

// [hw/ddrtm_top.v]
/*
 Device-side command timing tracker of a DDR3L memory: decodes commands
 on link clock rising edges, starts internal write transactions, tracks
 refresh, activation, precharge and short calibration busy time, and
 defers power-down entry until all of those except calibration have finished.
 Assumes link pins are asynchronous to MCLK_I and sampled through ddrtm_sync;
 link clock period must exceed two MCLK_I periods.
*/
`timescale 1ns/1ns
`include "ddrtm_map.vh"
// Operation
// - BL8 and OTF chop write start WL+4
// - fixed chop write start WL+2
// - accept CKE low, finish operations first
// - short calibration completes within 64 cycles
module ddrtm_top #(
    parameter WL_W = 6,
    parameter MCLK_NS = 50,
    parameter ACT_BUSY_CK = 8'd4,
    parameter PRE_BUSY_CK = 8'd4
) (
    // Clock and reset
    input wire MCLK_I,
    input wire RST_B_I,
    // Link pins
    input wire LINK_CK_I,
    input wire CKE_I,
    input wire CS_B_I,
    input wire RAS_B_I,
    input wire CAS_B_I,
    input wire WE_B_I,
    input wire CHOP_OTF_I,
    // Static configuration from mode settings
    input wire [WL_W-1:0] WRITE_LATENCY_I,
    input wire CHOP_FIXED_I,
    input wire LEVEL_MODE_I,
    // Status
    output reg WRITE_START_O,
    output reg REFRESH_BUSY_O,
    output reg ROW_BUSY_O,
    output reg ZQ_BUSY_O,
    output reg POWERDOWN_O,
    output reg LEVEL_STROBE_OK_O,
    output reg LEVEL_EDGE_OK_O
);
    localparam [15:0] REFRESH_MCLK = (`DDRTM_REFRESH_CYCLE_NS + MCLK_NS - 1) / MCLK_NS;
    localparam ST_IDLE = 3'b001;
    localparam ST_BUSY = 3'b010;
    localparam ST_PDOWN = 3'b100;
    // ==========================================
    // Reset release
    reg [1:0] rst_pipe;
    wire rst_b = rst_pipe[1];
    always @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            rst_pipe <= 2'b00;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    // ==========================================
    // Pin synchronisation and link edge detection
    wire [7:0] pins_s;
    ddrtm_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk_i(MCLK_I),
        .rst_b_i(rst_b),
        .d_i({LINK_CK_I, CKE_I, CS_B_I, RAS_B_I, CAS_B_I, WE_B_I, CHOP_OTF_I, LEVEL_MODE_I}),
        .q_o(pins_s)
    );
    reg ck_d;
    wire ck_rise = pins_s[7] & ~ck_d;
    wire cke_s = pins_s[6];
    wire [3:0] cmd_s = pins_s[5:2];
    wire chop_s = pins_s[1];
    wire level_s = pins_s[0];
    // Starts high; pins_s starts low, so a link clock already high at reset release still gives one edge
    always @(posedge MCLK_I or negedge rst_b)
    begin
        if (!rst_b)
            ck_d <= 1'b1;
        else
            ck_d <= pins_s[7];
    end
    function is_cmd;
        input [3:0] c;
        input [3:0] code;
        begin
            is_cmd = (c[3] == 1'b0) && (c[2:0] == code[2:0]);
        end
    endfunction
    wire cmd_edge = ck_rise & cke_s;
    wire do_ref = cmd_edge & is_cmd(cmd_s, `DDRTM_CMD_REF);
    wire do_act = cmd_edge & is_cmd(cmd_s, `DDRTM_CMD_ACT);
    wire do_pre = cmd_edge & is_cmd(cmd_s, `DDRTM_CMD_PRE);
    wire do_wr = cmd_edge & is_cmd(cmd_s, `DDRTM_CMD_WR);
    wire do_zq = cmd_edge & is_cmd(cmd_s, `DDRTM_CMD_ZQ);
    // ==========================================
    // Internal write start after write latency
    reg [WL_W:0] wr_cnt;
    reg wr_pend;
    wire [WL_W:0] wr_span = {1'b0, WRITE_LATENCY_I} +
        (CHOP_FIXED_I ? `DDRTM_WSTART_BC4_CK : `DDRTM_WSTART_BL8_CK);
    always @(posedge MCLK_I or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_cnt <= {(WL_W+1){1'b0}};
            wr_pend <= 1'b0;
            WRITE_START_O <= 1'b0;
        end
        else
        begin
            WRITE_START_O <= 1'b0;
            if (do_wr)
            begin
                wr_cnt <= wr_span;
                wr_pend <= 1'b1;
            end
            else if (wr_pend && ck_rise)
            begin
                if (wr_cnt == {{WL_W{1'b0}}, 1'b1})
                begin
                    wr_pend <= 1'b0;
                    WRITE_START_O <= 1'b1;
                end
                wr_cnt <= wr_cnt - {{WL_W{1'b0}}, 1'b1};
            end
        end
    end
    // ==========================================
    // Refresh, row and calibration busy timers
    reg [15:0] ref_cnt;
    reg [7:0] row_cnt;
    reg [7:0] zq_cnt;
    always @(posedge MCLK_I or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ref_cnt <= 16'h0000;
            row_cnt <= 8'h00;
            zq_cnt <= 8'h00;
            REFRESH_BUSY_O <= 1'b0;
            ROW_BUSY_O <= 1'b0;
            ZQ_BUSY_O <= 1'b0;
        end
        else
        begin
            if (do_ref)
                ref_cnt <= REFRESH_MCLK;
            else if (ref_cnt != 16'h0000)
                ref_cnt <= ref_cnt - 16'h0001;
            if (do_act)
                row_cnt <= ACT_BUSY_CK;
            else if (do_pre)
                row_cnt <= PRE_BUSY_CK;
            else if (ck_rise && row_cnt != 8'h00)
                row_cnt <= row_cnt - 8'h01;
            if (do_zq)
                zq_cnt <= `DDRTM_ZQCS_CK;
            else if (ck_rise && zq_cnt != 8'h00)
                zq_cnt <= zq_cnt - 8'h01;
            REFRESH_BUSY_O <= do_ref | (ref_cnt > 16'h0001);
            ROW_BUSY_O <= do_act | do_pre | (row_cnt > 8'h01) | (row_cnt == 8'h01 && !ck_rise);
            ZQ_BUSY_O <= do_zq | (zq_cnt > 8'h01) | (zq_cnt == 8'h01 && !ck_rise);
        end
    end
    wire ops_busy = (ref_cnt != 16'h0000) | (row_cnt != 8'h00) | wr_pend;
    // ==========================================
    // Power-down entry, deferred until operations finish
    reg [2:0] pd_state;
    reg [2:0] next_pd_state;
    wire cke_low_edge = ck_rise & ~cke_s;
    always @*
    begin
        next_pd_state = pd_state;
        case (pd_state)
            ST_IDLE:
                if (cke_low_edge)
                    next_pd_state = ops_busy ? ST_BUSY : ST_PDOWN;
            ST_BUSY:
                if (ck_rise && cke_s)
                    next_pd_state = ST_IDLE;
                else if (!ops_busy)
                    next_pd_state = ST_PDOWN;
            ST_PDOWN:
                if (ck_rise && cke_s)
                    next_pd_state = ST_IDLE;
            default:
                next_pd_state = ST_IDLE;
        endcase
    end
    always @(posedge MCLK_I or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pd_state <= ST_IDLE;
            POWERDOWN_O <= 1'b0;
        end
        else
        begin
            pd_state <= next_pd_state;
            POWERDOWN_O <= (next_pd_state == ST_PDOWN);
        end
    end
    // ==========================================
    // Write leveling strobe windows
    reg [7:0] lvl_cnt;
    always @(posedge MCLK_I or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lvl_cnt <= 8'h00;
            LEVEL_STROBE_OK_O <= 1'b0;
            LEVEL_EDGE_OK_O <= 1'b0;
        end
        else
        begin
            if (!level_s)
                lvl_cnt <= 8'h00;
            else if (ck_rise && lvl_cnt != `DDRTM_LEVEL_FIRST_STROBE_CK)
                lvl_cnt <= lvl_cnt + 8'h01;
            LEVEL_STROBE_OK_O <= level_s && (lvl_cnt >= `DDRTM_LEVEL_STROBE_DRIVE_CK);
            LEVEL_EDGE_OK_O <= level_s && (lvl_cnt >= `DDRTM_LEVEL_FIRST_STROBE_CK);
        end
    end
endmodule
